// ===== bench/dtps_rc_model.sv
`timescale 1ns/10ps
`default_nettype none
module dtps_rc_model
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        pwmIn,
  output logic [10:0]      widthSeen,
  output logic             widthStb,
  output logic [15:0]      filtLevel
);
  logic [10:0] highCnt;
  logic        pwmPrev;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      highCnt   <= 11'h000;
      pwmPrev   <= 1'b0;
      widthStb  <= 1'b0;
      widthSeen <= 11'h000;
    end
    else if (ce)
    begin
      pwmPrev  <= pwmIn;
      widthStb <= pwmIn & ~pwmPrev;
      if (pwmIn && !pwmPrev)
      begin
        widthSeen <= highCnt;
        highCnt   <= 11'h001;
      end
      else
        highCnt <= highCnt + {10'h000, pwmIn};
    end
    else
      widthStb <= 1'b0;
  end
  // leaky integrator, stands in for the RC stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      filtLevel <= 16'h0000;
    else
      filtLevel <= filtLevel - (filtLevel >> 6) + (pwmIn ? 16'h03FF : 16'h0000);
  end
endmodule
`default_nettype wire

// ===== bench/dtps_synth_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dtps_synth_checker
  import dtps_pkg::*;
#(
  parameter int CRYSTAL_HZ   = 9830400,
  parameter int CLK_HZ       = 40000000,
  parameter int PWM_CHANNEL  = 1,
  parameter int TONE_SAMPLES = 480,
  parameter int GAP_SAMPLES  = 480,
  parameter int WARM_SAMPLES = 12288
)
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic [7:0] digitData,
  input wire logic       digitValid,
  input wire logic       digitReady,
  input wire logic       pwmOut1,
  input wire logic       pwmOut2,
  input wire logic       toneActive,
  input wire logic       dialDone
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Integer sample length; slack of one sample covers the rounding
  localparam int SCLK = CLK_HZ / (CRYSTAL_HZ / 1024);
  localparam int TMIN = (TONE_SAMPLES - 1) * SCLK;
  localparam int TMAX = (TONE_SAMPLES + 1) * SCLK;
  localparam int GMIN = (GAP_SAMPLES - 1) * SCLK;
  localparam int WMIN = (WARM_SAMPLES - 1) * SCLK;
  wire logic  pwmAct  = (PWM_CHANNEL == 2) ? pwmOut2 : pwmOut1;
  wire logic  pwmIdle = (PWM_CHANNEL == 2) ? pwmOut1 : pwmOut2;
  logic [9:0] perCnt;
  logic       riseSeen, pwmPrev, toneReg, toneSeen;
  int         toneLen, lowLen, sinceRst;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      perCnt   <= 10'h000;
      riseSeen <= 1'b0;
      pwmPrev  <= 1'b0;
    end
    else if (ce)
    begin
      pwmPrev  <= pwmAct;
      riseSeen <= riseSeen | (pwmAct & ~pwmPrev);
      perCnt   <= (pwmAct & ~pwmPrev) ? 10'h001 : perCnt + 10'h001;
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      toneLen  <= 0;
      lowLen   <= 0;
      sinceRst <= 0;
      toneReg  <= 1'b0;
      toneSeen <= 1'b0;
    end
    else if (ce)
    begin
      toneReg  <= toneActive;
      toneSeen <= toneSeen | toneActive;
      toneLen  <= toneActive ? toneLen + 1 : 0;
      lowLen   <= toneActive ? 0 : lowLen + 1;
      sinceRst <= (sinceRst < WMIN) ? sinceRst + 1 : sinceRst;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_IDLE_CHANNEL_LOW: assert property (pwmIdle == 1'b0)
    else $error("unused pwm channel not low");
  AST_RESET_FROM_ZERO: assert property (
    $fell(sys_rst) |-> !pwmOut1 && !pwmOut2 && !toneActive && !dialDone)
    else $error("outputs not quiet after reset");
  AST_PWM_PERIOD: assert property (
    pwmAct && !pwmPrev && riseSeen |-> perCnt == 10'h000)
    else $error("pwm period not 1024 clocks");
  AST_TONE_LENGTH: assert property (
    !toneActive && toneReg |-> toneLen inside {[TMIN:TMAX]})
    else $error("tone length out of bounds");
  AST_GAP_LENGTH: assert property (
    toneActive && !toneReg && toneSeen |-> lowLen >= GMIN)
    else $error("gap between tones too short");
  AST_NO_TONE_IN_WARMUP: assert property (toneActive |-> sinceRst >= WMIN)
    else $error("tone before warm-up end");
  AST_DONE_HOLDS: assert property (dialDone |=> dialDone)
    else $error("done flag dropped without reset");
  AST_SILENT_AFTER_DONE: assert property (dialDone |-> !toneActive)
    else $error("tone after terminator");
  AST_NO_POP_AFTER_DONE: assert property (
    dialDone && !digitReady |=> $stable(digitReady))
    else $error("fifo popped after terminator");
  COV_TONE: cover property (toneActive && !toneReg);
  COV_DONE: cover property ($rose(dialDone));
  COV_FULL: cover property (digitValid && !digitReady);
  COV_GAP: cover property (toneActive && !toneReg && toneSeen);
endmodule

bind dtps_synth dtps_synth_checker #(
  .CRYSTAL_HZ(CRYSTAL_HZ), .CLK_HZ(CLK_HZ), .PWM_CHANNEL(PWM_CHANNEL),
  .TONE_SAMPLES(TONE_SAMPLES), .GAP_SAMPLES(GAP_SAMPLES), .WARM_SAMPLES(WARM_SAMPLES)
) u_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .digitData(digitData), .digitValid(digitValid),
  .digitReady(digitReady), .pwmOut1(pwmOut1), .pwmOut2(pwmOut2),
  .toneActive(toneActive), .dialDone(dialDone)
);
`default_nettype wire

// ===== bench/dtps_synth_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dtps_synth_tb;
  import dtps_pkg::*;
  // Fast crystal: one count a clock, 256 clocks a sample
  localparam int CRY   = 160000000;
  localparam int LIMIT = 100000;
  logic        clk, sys_rst, ce, digitValid, toneQ, doneQ, warmDone, live;
  logic [7:0]  digitData;
  logic [10:0] prevW;
  logic [1:0]  noteQ[$];
  int          errTotal, cmpCount, cycles, devCount, doneAge;
  wire logic   digitReady, pwm1, pwm2, toneActive, dialDone;
  wire logic   readyB, pwmB1, pwmB2, toneB, doneB, widthStb;
  wire logic [10:0] widthSeen;
  wire logic [15:0] filtLevel;
  dtps_synth #(.CRYSTAL_HZ(CRY), .PWM_CHANNEL(1), .TONE_SAMPLES(8), .GAP_SAMPLES(4),
    .WARM_SAMPLES(128)) u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .digitData(digitData),
    .digitValid(digitValid), .digitReady(digitReady), .pwmOut1(pwm1), .pwmOut2(pwm2),
    .toneActive(toneActive), .dialDone(dialDone));
  dtps_synth #(.CRYSTAL_HZ(CRY), .PWM_CHANNEL(2), .TONE_SAMPLES(8), .GAP_SAMPLES(4),
    .WARM_SAMPLES(128)) u_dut2 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .digitData(digitData),
    .digitValid(digitValid), .digitReady(readyB), .pwmOut1(pwmB1), .pwmOut2(pwmB2),
    .toneActive(toneB), .dialDone(doneB));
  dtps_rc_model u_filt (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pwmIn(pwm1),
    .widthSeen(widthSeen), .widthStb(widthStb), .filtLevel(filtLevel));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic giveVerdict();
    $display("Comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input int expV, input logic [10:0] seenV);
    cmpCount++;
    if (seenV !== 11'(expV))
    begin
      errTotal++;
      $display("ERROR %s expected %0d seen %0d", what, expV, seenV);
    end
  endtask
  task automatic take(input logic [1:0] kind);
    if (noteQ.size() == 0)
      check("event without note", 0, {9'd0, kind});
    else
      check("event kind", noteQ.pop_front(), {9'd0, kind});
  endtask
  // Valid may dip one cycle between words; caller drops it after the last
  task automatic push(input logic [7:0] code);
    int n;
    int bub;
    n = 0;
    bub = $urandom_range(1);
    digitData  <= code;
    digitValid <= (bub == 0);
    if (bub != 0)
    begin
      @(posedge clk);
      digitValid <= 1'b1;
    end
    @(negedge clk);
    while (digitReady !== 1'b1 && n < 200000)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    if (live && code < 8'h10)
      noteQ.push_back(2'd1);
    if (live && code == 8'h10)
      noteQ.push_back(2'd2);
    if (code == 8'h10)
      live = 1'b0;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errTotal++;
      $display("ERROR timeout expected %0d seen %0d", LIMIT - 1, cycles);
      giveVerdict();
    end
  end
  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (sys_rst === 1'b0)
    begin
      if (toneActive === 1'b1 && !toneQ) take(2'd1);
      if (dialDone === 1'b1 && !doneQ) take(2'd2);
      if (toneActive === 1'b1)
        warmDone = 1'b1;
      if (dialDone === 1'b1)
        doneAge++;
      if (widthStb === 1'b1)
      begin
        if (!warmDone)
          check("warm ramp", 1, {10'd0, widthSeen >= prevW && widthSeen <= 11'd512});
        else
          check("width range", 1, {10'd0, widthSeen >= 11'd2 && widthSeen <= 11'd1022});
        if (warmDone && dialDone !== 1'b1 && widthSeen > 11'd512)
          devCount++;
        if (doneAge > 2100) check("idle width", 512, widthSeen);
        check("second channel", 1, {10'd0, pwmB2 === pwm1 && pwmB1 === 1'b0});
        prevW = widthSeen;
      end
    end
    toneQ = (toneActive === 1'b1);
    doneQ = (dialDone === 1'b1);
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] codes[$];
    logic [7:0] tmp;
    int         k;
    int         j;
    sys_rst = 1'b1;
    ce = 1'b1;
    digitValid = 1'b0;
    digitData = 8'h00;
    {errTotal, cmpCount, cycles, devCount, doneAge} = '0;
    {toneQ, doneQ, warmDone, prevW} = '0;
    live = 1'b1;
    k = $urandom(32'h8DADC169);
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (1 + $urandom_range(7)) @(posedge clk);
    // Random enable pattern; all state must simply pause
    repeat (8)
    begin
      ce <= 1'($urandom_range(1));
      @(posedge clk);
    end
    ce <= 1'b1;
    for (k = 0; k < 16; k++)
      codes.push_back(k[7:0]);
    for (k = 15; k > 0; k--)
    begin
      j = $urandom_range(k);
      tmp = codes[k];
      codes[k] = codes[j];
      codes[j] = tmp;
    end
    // Out-of-range code mid-stream, then terminator, then words that must stay idle
    codes.insert(8, 8'h11 + 8'($urandom_range(238)));
    codes.push_back(8'h10);
    for (k = 0; k < 16; k++)
      codes.push_back(8'($urandom_range(15)));
    foreach (codes[k])
      push(codes[k]);
    digitData <= 8'h05;
    repeat (40) @(negedge clk);
    check("ready with full fifo", 0, {10'd0, digitReady});
    check("done flag", 1, {10'd0, dialDone});
    @(posedge clk);
    digitValid <= 1'b0;
    repeat (4096) @(posedge clk);
    check("tone periods off mid", 1, {10'd0, devCount >= 16});
    check("notes left", 0, 11'(noteQ.size()));
    giveVerdict();
  end
endmodule
`default_nettype wire

// ===== hw/dtps_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module dtps_fifo
  import dtps_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic     clk,
  input wire logic     sys_rst,
  input wire logic     ce,
  dtps_stream_if.sink   inPort,
  dtps_stream_if.source outPort
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : gCheck
    $error("dtps_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtrReg;
  logic [AW-1:0]    rdPtrReg;
  logic [AW:0]      countReg;
  logic             notFullReg;
  logic             doWrite;
  logic             doRead;
  logic [AW:0]      count_next;

  assign doWrite = inPort.valid & notFullReg & ce;
  assign doRead  = outPort.ready & (countReg != '0) & ce;
  assign count_next = countReg + (AW + 1)'(doWrite) - (AW + 1)'(doRead);

  assign inPort.ready  = notFullReg;
  assign outPort.valid = (countReg != '0);
  assign outPort.data  = mem[rdPtrReg];

  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtrReg] <= inPort.data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
      notFullReg <= 1'b1;
    end
    else if (ce)
    begin
      if (doWrite)
        wrPtrReg <= wrPtrReg + 1'b1;
      if (doRead)
        rdPtrReg <= rdPtrReg + 1'b1;
      countReg <= count_next;
      notFullReg <= (count_next != FULL_CNT);
    end
  end
endmodule
`default_nettype wire

// ===== hw/dtps_params.svh
`ifndef DTPS_PARAMS_SVH
`define DTPS_PARAMS_SVH

// ----------------------------------------
// Clocks and sample timing
// ----------------------------------------
`define DTPS_CLK_HZ        40000000
`define DTPS_CRYSTAL_HZ    9830400
`define DTPS_PRESCALE      4
`define DTPS_EVENT_COUNTS  256
`define DTPS_COUNTER_MAX   8'hFF

// ----------------------------------------
// Durations
// ----------------------------------------
`define DTPS_TONE_MS       50
`define DTPS_GAP_MS        50
`define DTPS_MS_PER_S      1000
`define DTPS_WARM_SAMPLES  12288

// ----------------------------------------
// Tone frequencies in Hz
// ----------------------------------------
`define DTPS_LOW0_HZ       697
`define DTPS_LOW1_HZ       770
`define DTPS_LOW2_HZ       852
`define DTPS_LOW3_HZ       941
`define DTPS_HIGH0_HZ      1209
`define DTPS_HIGH1_HZ      1335
`define DTPS_HIGH2_HZ      1477
`define DTPS_HIGH3_HZ      1633

// ----------------------------------------
// Table, phase and PWM levels
// ----------------------------------------
`define DTPS_TABLE_SIZE    256
`define DTPS_PHASE_FRAC    8
`define DTPS_SINE_AMP      255.0
`define DTPS_WIDTH_MID     10'h200
`define DTPS_WIDTH_ZERO    10'h000
`define DTPS_PWM_MAX       10'h3FF

// ----------------------------------------
// Digit codes
// ----------------------------------------
`define DTPS_TERM_CODE     8'h10
`define DTPS_CODE_STAR     4'hE
`define DTPS_CODE_HASH     4'hF
`define DTPS_CODE_ZERO     4'h0
`define DTPS_CODE_A        4'hA

`endif

// ===== hw/dtps_pkg.sv
package dtps_pkg;
  typedef enum logic [2:0] {
    sWarm,
    sFetch,
    sTone,
    sGap,
    sDone
  } dtps_state_e;
  typedef logic [9:0] dtps_width_t;
  typedef logic [7:0] dtps_code_t;
endpackage

// ===== hw/dtps_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dtps_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== hw/dtps_synth.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtps_params.svh"

module dtps_synth
  import dtps_pkg::*;
#(
  parameter int CRYSTAL_HZ   = `DTPS_CRYSTAL_HZ,
  parameter int CLK_HZ       = `DTPS_CLK_HZ,
  parameter int PWM_CHANNEL  = 1,
  parameter int FIFO_DEPTH   = 16,
  parameter int SAMPLE_HZ    = CRYSTAL_HZ / (`DTPS_PRESCALE * `DTPS_EVENT_COUNTS),
  parameter int TONE_SAMPLES = (`DTPS_TONE_MS * SAMPLE_HZ + `DTPS_MS_PER_S - 1)
                               / `DTPS_MS_PER_S,
  parameter int GAP_SAMPLES  = (`DTPS_GAP_MS * SAMPLE_HZ + `DTPS_MS_PER_S - 1)
                               / `DTPS_MS_PER_S,
  parameter int WARM_SAMPLES = `DTPS_WARM_SAMPLES
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [7:0] digitData,
  input  wire logic       digitValid,
  output logic            digitReady,
  output logic            pwmOut1,
  output logic            pwmOut2,
  output logic            toneActive,
  output logic            dialDone
);
  // ----------------------------------------
  // Derived constants
  // ----------------------------------------
  localparam int PHASE_W   = 8 + `DTPS_PHASE_FRAC;
  localparam int WARM_STEP = (WARM_SAMPLES >= int'(`DTPS_WIDTH_MID))
                             ? WARM_SAMPLES / int'(`DTPS_WIDTH_MID) : 1;
  // Short warm-ups climb in coarser steps so the ramp still lands on mid
  localparam int WARM_INC  = (WARM_SAMPLES >= int'(`DTPS_WIDTH_MID)) ? 1
                             : int'(`DTPS_WIDTH_MID) / ((WARM_SAMPLES > 0) ? WARM_SAMPLES : 1);
  localparam int TMR_MAX   = (TONE_SAMPLES > GAP_SAMPLES) ? TONE_SAMPLES : GAP_SAMPLES;
  localparam int TMR_W     = $clog2(TMR_MAX + 1) + 1;
  localparam int NCO_MOD   = CLK_HZ * `DTPS_PRESCALE;
  localparam logic [31:0] NCO_STEP = 32'(CRYSTAL_HZ);
  localparam logic [31:0] NCO_WRAP = 32'(NCO_MOD);

  if (PWM_CHANNEL != 1 && PWM_CHANNEL != 2)
  begin : gChanCheck
    $error("dtps_synth: PWM_CHANNEL must be 1 or 2");
  end
  if (CRYSTAL_HZ > NCO_MOD || TONE_SAMPLES < 1 || GAP_SAMPLES < 1 || WARM_SAMPLES < 1
      || (int'(`DTPS_WIDTH_MID) % WARM_INC) != 0)
  begin : gRateCheck
    $error("dtps_synth: clock, crystal or duration values unusable");
  end

  // Step is 256*f/fs scaled by 2^frac; 64-bit to avoid overflow
  function automatic logic [PHASE_W-1:0] phaseStep(input longint freqHz);
    longint num;
    longint den;
    num = freqHz * `DTPS_TABLE_SIZE * `DTPS_PRESCALE * `DTPS_EVENT_COUNTS;
    num = num << `DTPS_PHASE_FRAC;
    den = longint'(CRYSTAL_HZ);
    return PHASE_W'((num + den / 2) / den);
  endfunction

  function automatic dtps_width_t sineValue(input int idx);
    real ang;
    ang = 2.0 * 3.14159265358979 * real'(idx) / real'(`DTPS_TABLE_SIZE);
    return 10'($rtoi(real'(`DTPS_WIDTH_MID) + `DTPS_SINE_AMP * $sin(ang) + 0.5));
  endfunction

  // ----------------------------------------
  // Step tables for both groups
  // ----------------------------------------
  // four low and four high frequencies
  // rounded steps with 8 fraction bits
  // rounding error far below 1.5 percent
  localparam logic [PHASE_W-1:0] LOW_STEP [4] = '{
    phaseStep(`DTPS_LOW0_HZ), phaseStep(`DTPS_LOW1_HZ),
    phaseStep(`DTPS_LOW2_HZ), phaseStep(`DTPS_LOW3_HZ)};
  localparam logic [PHASE_W-1:0] HIGH_STEP [4] = '{
    phaseStep(`DTPS_HIGH0_HZ), phaseStep(`DTPS_HIGH1_HZ),
    phaseStep(`DTPS_HIGH2_HZ), phaseStep(`DTPS_HIGH3_HZ)};

  // ----------------------------------------
  // Sine table
  // ----------------------------------------
  // one full period in 256 entries
  dtps_width_t sineRom [`DTPS_TABLE_SIZE];
  for (genvar g = 0; g < `DTPS_TABLE_SIZE; g++)
  begin : gRom
    assign sineRom[g] = sineValue(g);
  end

  // ----------------------------------------
  // Digit FIFO
  // ----------------------------------------
  dtps_stream_if #(.W(8)) inIf ();
  dtps_stream_if #(.W(8)) outIf ();

  logic popDigit;

  assign inIf.data   = digitData;
  assign inIf.valid  = digitValid;
  assign digitReady  = inIf.ready;
  assign outIf.ready = popDigit;

  dtps_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .inPort  (inIf),
    .outPort (outIf)
  );

  // ----------------------------------------
  // Sample event generation
  // ----------------------------------------
  logic [31:0] ncoReg;
  logic [32:0] ncoSum;
  logic        countTick;
  logic [7:0]  eventCountReg;
  logic        sampleTickReg;

  // fractional divider tracks any crystal value up to four times the clock
  assign ncoSum    = {1'b0, ncoReg} + {1'b0, NCO_STEP};
  assign countTick = (ncoSum >= {1'b0, NCO_WRAP});

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ncoReg <= '0;
    else if (ce)
      ncoReg <= countTick ? 32'(ncoSum - {1'b0, NCO_WRAP}) : ncoSum[31:0];
  end

  // event on every 256th crystal/4 count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      eventCountReg <= '0;
      sampleTickReg <= 1'b0;
    end
    else if (ce)
    begin
      sampleTickReg <= countTick && (eventCountReg == `DTPS_COUNTER_MAX);
      if (countTick)
        eventCountReg <= eventCountReg + 1'b1;
    end
  end

  // ----------------------------------------
  // Digit decode
  // ----------------------------------------
  logic [1:0] rowSel;
  logic [1:0] colSel;
  logic [3:0] codeNib;

  assign codeNib = outIf.data[3:0];

  // code order 0-9, A-D, star, hash
  always_comb
  begin
    rowSel = 2'd3;
    colSel = 2'd1;
    if (codeNib == `DTPS_CODE_ZERO)
    begin
      rowSel = 2'd3;
      colSel = 2'd1;
    end
    else if (codeNib < `DTPS_CODE_A)
    begin
      rowSel = 2'((codeNib - 4'd1) / 4'd3);
      colSel = 2'((codeNib - 4'd1) % 4'd3);
    end
    else if (codeNib < `DTPS_CODE_STAR)
    begin
      rowSel = 2'(codeNib - `DTPS_CODE_A);
      colSel = 2'd3;
    end
    else
    begin
      rowSel = 2'd3;
      colSel = (codeNib == `DTPS_CODE_HASH) ? 2'd2 : 2'd0;
    end
  end

  // ----------------------------------------
  // Dial sequencer
  // ----------------------------------------
  dtps_state_e        stateReg;
  logic [TMR_W-1:0]   timerReg;
  logic [15:0]        warmCntReg;
  logic [PHASE_W-1:0] lowStepReg;
  logic [PHASE_W-1:0] highStepReg;
  dtps_width_t        widthReg;
  logic               codeValid;
  logic               codeTerm;

  assign codeTerm  = (outIf.data == `DTPS_TERM_CODE);
  assign codeValid = (outIf.data < `DTPS_TERM_CODE);
  // Unknown codes above the terminator are dropped silently
  assign popDigit  = (stateReg == sFetch) && outIf.valid && ce;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stateReg    <= sWarm;
      timerReg    <= '0;
      warmCntReg  <= '0;
      lowStepReg  <= '0;
      highStepReg <= '0;
    end
    else if (ce)
    begin
      unique case (stateReg)
        sWarm:
        begin
          if (sampleTickReg)
          begin
            if (warmCntReg == 16'(WARM_STEP - 1))
              warmCntReg <= '0;
            else
              warmCntReg <= warmCntReg + 1'b1;
          end
          if (widthReg == `DTPS_WIDTH_MID)
            stateReg <= sFetch;
        end
        sFetch:
        begin
          if (outIf.valid)
          begin
            if (codeTerm)
              stateReg <= sDone;
            else if (codeValid)
            begin
              // one low and one high step per key
              lowStepReg  <= LOW_STEP[rowSel];
              highStepReg <= HIGH_STEP[colSel];
              timerReg    <= TMR_W'(TONE_SAMPLES);
              stateReg    <= sTone;
            end
          end
        end
        sTone:
        begin
          if (sampleTickReg)
          begin
            if (timerReg == TMR_W'(1))
            begin
              timerReg <= TMR_W'(GAP_SAMPLES);
              stateReg <= sGap;
            end
            else
              timerReg <= timerReg - 1'b1;
          end
        end
        sGap:
        begin
          if (sampleTickReg)
          begin
            if (timerReg == TMR_W'(1))
              stateReg <= sFetch;
            else
              timerReg <= timerReg - 1'b1;
          end
        end
        sDone:
          stateReg <= sDone;
      endcase
    end
  end

  // ----------------------------------------
  // Phase accumulators
  // ----------------------------------------
  logic [PHASE_W-1:0] lowPhaseReg;
  logic [PHASE_W-1:0] highPhaseReg;

  // top 8 bits index, wrap modulo 256
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lowPhaseReg  <= '0;
      highPhaseReg <= '0;
    end
    else if (ce)
    begin
      if (stateReg != sTone)
      begin
        lowPhaseReg  <= '0;
        highPhaseReg <= '0;
      end
      else if (sampleTickReg)
      begin
        lowPhaseReg  <= lowPhaseReg + lowStepReg;
        highPhaseReg <= highPhaseReg + highStepReg;
      end
    end
  end

  // ----------------------------------------
  // Sample sum and width
  // ----------------------------------------
  dtps_width_t lowSample;
  dtps_width_t highSample;
  logic [10:0] sumWide;

  assign lowSample  = sineRom[lowPhaseReg[PHASE_W-1 -: 8]];
  assign highSample = sineRom[highPhaseReg[PHASE_W-1 -: 8]];
  // remove one mid offset, stays within 10 bits
  assign sumWide = {1'b0, lowSample} + {1'b0, highSample} - {1'b0, `DTPS_WIDTH_MID};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      widthReg <= `DTPS_WIDTH_ZERO;
    else if (ce)
    begin
      unique case (stateReg)
        // ramp 0 to 512 in warm-up
        sWarm:
          if (sampleTickReg && warmCntReg == 16'(WARM_STEP - 1)
              && widthReg != `DTPS_WIDTH_MID)
            widthReg <= widthReg + 10'(WARM_INC);
        // new width on every sample event
        sTone:
          if (sampleTickReg)
            widthReg <= sumWide[9:0];
        // mid level between and after digits
        default:
          widthReg <= `DTPS_WIDTH_MID;
      endcase
    end
  end

  // ----------------------------------------
  // PWM output
  // ----------------------------------------
  logic [9:0]  pwmCntReg;
  dtps_width_t dutyReg;
  logic        pwmLevel;

  // fixed 1024-clock period, duty reloaded at wrap
  // Reload at wrap avoids a torn pulse mid-period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwmCntReg <= '0;
      dutyReg   <= `DTPS_WIDTH_ZERO;
    end
    else if (ce)
    begin
      pwmCntReg <= pwmCntReg + 1'b1;
      if (pwmCntReg == `DTPS_PWM_MAX)
        dutyReg <= widthReg;
    end
  end

  assign pwmLevel = (pwmCntReg < dutyReg);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwmOut1 <= 1'b0;
      pwmOut2 <= 1'b0;
    end
    else if (ce)
    begin
      pwmOut1 <= (PWM_CHANNEL == 1) ? pwmLevel : 1'b0;
      pwmOut2 <= (PWM_CHANNEL == 2) ? pwmLevel : 1'b0;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      toneActive <= 1'b0;
      dialDone   <= 1'b0;
    end
    else if (ce)
    begin
      toneActive <= (stateReg == sTone);
      dialDone   <= (stateReg == sDone);
    end
  end
endmodule
`default_nettype wire
